// file: rtl/hcieg_pkg.sv
package hcieg_pkg;

  // Register map and field layout of the interrupt enable register.
  localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h28;
  localparam logic [31:0] IRQ_ENABLE_RESET = 32'h0000_0000;
  localparam int IRQ_ENABLE_BITS = 6;
  localparam int XFER_DONE_BIT = 0;
  localparam int XFER_ERROR_BIT = 1;
  localparam int PORT_CHANGE_BIT = 2;
  localparam int ROLLOVER_BIT = 3;
  localparam int SYSTEM_ERROR_BIT = 4;
  localparam int ASYNC_ADVANCE_BIT = 5;

  // Sources that wait for the next interrupt threshold boundary.
  localparam logic [5:0] DEFERRED_MASK = 6'h23;
  localparam logic [5:0] IMMEDIATE_MASK = 6'h1c;

  // One bit per status source, in register bit order.
  typedef struct packed {
    logic async_advance;
    logic system_error;
    logic rollover;
    logic port_change;
    logic xfer_error;
    logic xfer_done;
  } hcieg_src_t;

  // Register access port as seen by this block.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } hcieg_req_t;

  // Hardware events that set status flags.
  typedef struct packed {
    logic bus_fault;
    logic ioc_retired;
    logic short_packet;
    logic xfer_error;
    logic port_change;
    logic rollover;
    logic async_advance;
  } hcieg_evt_t;

endpackage : hcieg_pkg

// file: rtl/hcieg_gate.sv
module hcieg_gate (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire hcieg_pkg::hcieg_req_t req_i,
  output logic [31:0] rdata_o,
  input wire hcieg_pkg::hcieg_evt_t evt_i,
  input wire hcieg_pkg::hcieg_src_t status_clr_i,
  input wire logic threshold_i,
  input wire logic run_stop_set_i,
  output logic run_stop_o,
  output hcieg_pkg::hcieg_src_t status_o,
  output hcieg_pkg::hcieg_src_t irq_enable_o,
  output logic irq_o
);
  import hcieg_pkg::*;

  // Timing overview, counted in clock edges.
  // A write to the enable register is stored at the edge that takes it.
  // A hardware event sets its status flag at the edge that sees it.
  // An immediate source reaches the line one edge after its flag and enable
  // are both set, so two edges after the event.
  // A deferred source is caught by the threshold latch at a threshold edge and
  // reaches the line one edge later.
  // Read data stands for one cycle, the cycle after the read request.
  // Users must keep in mind that the line is a level: it stays high until every
  // enabled flag that feeds it has been cleared by software.

  // True when a register access targets the interrupt enable register.
  // Only this one offset is decoded, so accesses anywhere else leave it alone.
  function automatic logic enable_reg_hit(input logic [7:0] addr);
    enable_reg_hit = (addr == IRQ_ENABLE_OFFSET);
  endfunction : enable_reg_hit

  // True when any pending source falls inside the given delivery group.
  function automatic logic any_in_group(input logic [5:0] vec, input logic [5:0] mask);
    any_in_group = |(vec & mask);
  endfunction : any_in_group

  // Builds the read word from the stored enable bits.
  // The reserved upper bits always read as zero, whatever software wrote.
  function automatic logic [31:0] enable_word(input logic [5:0] bits);
    enable_word = {26'h0, bits};
  endfunction : enable_word

  // Stored enable bits and status flags, both in register bit order.
  logic [5:0] irq_enable_reg_q;
  logic [5:0] host_status_reg_q;
  logic [5:0] host_status_reg_d;

  // Hardware set events and software clear strobes as plain vectors.
  logic [5:0] set_vec;
  logic [5:0] clr_vec;

  // Per-source pending terms, each a flag gated by its own enable.
  logic async_advance_pend;
  logic system_error_pend;
  logic rollover_pend;
  logic port_change_pend;
  logic xfer_error_pend;
  logic xfer_done_pend;
  logic [5:0] active;

  // Delivery groups and register strobes.
  logic deferred_any;
  logic immediate_any;
  logic enable_wr;
  logic enable_rd;

  // Remaining state.
  logic deferred_q;
  logic run_stop_q;
  logic [31:0] rdata_q;

  // Decoded register strobes; an access to any other offset is ignored.
  // A request with both wr and rd high is served as both in the same cycle.
  assign enable_wr = req_i.wr & enable_reg_hit(req_i.addr);
  assign enable_rd = req_i.rd & enable_reg_hit(req_i.addr);

  // Enable register write. The reserved upper bits are not stored, so a
  // careless write of ones there cannot switch on a source that does not exist.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      irq_enable_reg_q <= IRQ_ENABLE_RESET[5:0];
    end else if (enable_wr) begin
      irq_enable_reg_q <= req_i.wdata[5:0];
    end
  end

  // Hardware set events, one bit per source.
  // Completion has two causes, so both are folded into the one flag.
  // A bus fault is the only cause of the system error flag.
  always_comb begin
    set_vec = 6'h00;
    set_vec[XFER_DONE_BIT] = evt_i.ioc_retired | evt_i.short_packet;
    set_vec[XFER_ERROR_BIT] = evt_i.xfer_error;
    set_vec[PORT_CHANGE_BIT] = evt_i.port_change;
    set_vec[ROLLOVER_BIT] = evt_i.rollover;
    set_vec[SYSTEM_ERROR_BIT] = evt_i.bus_fault;
    set_vec[ASYNC_ADVANCE_BIT] = evt_i.async_advance;
  end

  // Software clear strobes arrive in register bit order already.
  assign clr_vec = status_clr_i;

  // Next status value. The flags ignore the enables entirely, and a set beats a
  // clear in the same cycle so that an event landing on an acknowledge is kept.
  assign host_status_reg_d = (host_status_reg_q & ~clr_vec) | set_vec;

  // Status flags hold until software clears them.
  // Masked sources are stored exactly like enabled ones, which is what lets
  // software poll for them.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      host_status_reg_q <= 6'h00;
    end else begin
      host_status_reg_q <= host_status_reg_d;
    end
  end

  // A bus fault halts the schedule; the halt wins over a software start in the
  // same cycle, because restarting into a faulted system would repeat the fault.
  // Software has to start the schedule again once it has handled the fault.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      run_stop_q <= 1'b0;
    end else if (evt_i.bus_fault) begin
      run_stop_q <= 1'b0;
    end else if (run_stop_set_i) begin
      run_stop_q <= 1'b1;
    end
  end

  // Each source is pending while its flag and its enable are both set.
  // Masking happens only here, after the flag, so masked events stay visible.
  assign async_advance_pend = host_status_reg_q[ASYNC_ADVANCE_BIT] &
                              irq_enable_reg_q[ASYNC_ADVANCE_BIT];
  assign system_error_pend = host_status_reg_q[SYSTEM_ERROR_BIT] &
                             irq_enable_reg_q[SYSTEM_ERROR_BIT];
  assign rollover_pend = host_status_reg_q[ROLLOVER_BIT] &
                         irq_enable_reg_q[ROLLOVER_BIT];
  assign port_change_pend = host_status_reg_q[PORT_CHANGE_BIT] &
                            irq_enable_reg_q[PORT_CHANGE_BIT];
  assign xfer_error_pend = host_status_reg_q[XFER_ERROR_BIT] &
                           irq_enable_reg_q[XFER_ERROR_BIT];
  assign xfer_done_pend = host_status_reg_q[XFER_DONE_BIT] &
                          irq_enable_reg_q[XFER_DONE_BIT];

  // Pending terms gathered back into register bit order.
  always_comb begin
    active = 6'h00;
    active[ASYNC_ADVANCE_BIT] = async_advance_pend;
    active[SYSTEM_ERROR_BIT] = system_error_pend;
    active[ROLLOVER_BIT] = rollover_pend;
    active[PORT_CHANGE_BIT] = port_change_pend;
    active[XFER_ERROR_BIT] = xfer_error_pend;
    active[XFER_DONE_BIT] = xfer_done_pend;
  end

  // Split into the two delivery groups. The masks are fixed constants, so a
  // source cannot be moved between groups at run time.
  assign deferred_any = any_in_group(active, DEFERRED_MASK);
  assign immediate_any = any_in_group(active, IMMEDIATE_MASK);

  // Deferred sources latch at a threshold and drop once acknowledged.
  // Holding until acknowledgement avoids a pulse that software could miss.
  // A deferred source that turns up between thresholds waits for the next one,
  // unless the latch is already held by another deferred source; then it keeps the latch held.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      deferred_q <= 1'b0;
    end else if (threshold_i) begin
      deferred_q <= deferred_any;
    end else if (!deferred_any) begin
      deferred_q <= 1'b0;
    end
  end

  // Immediate sources reach the line at once; deferred ones via the latch.
  // The line is registered so that it never glitches while flags change.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= deferred_q | immediate_any;
    end
  end

  // Registered read data; unmapped offsets read zero.
  // The word falls back to zero after one cycle, so the requester must take
  // it in the cycle after its read.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (enable_rd) begin
      rdata_q <= enable_word(irq_enable_reg_q);
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  // Outputs, all straight from registers.
  assign rdata_o = rdata_q;
  assign run_stop_o = run_stop_q;
  assign status_o = hcieg_src_t'(host_status_reg_q);
  assign irq_enable_o = hcieg_src_t'(irq_enable_reg_q);

endmodule : hcieg_gate

// file: bench/hcieg_gate_sva.sv
module hcieg_gate_sva (
  input logic clk_i,
  input logic nrst_i,
  input hcieg_pkg::hcieg_evt_t evt_i,
  input logic threshold_i,
  input logic run_stop_o,
  input hcieg_pkg::hcieg_src_t status_o,
  input hcieg_pkg::hcieg_src_t irq_enable_o,
  input logic irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import hcieg_pkg::*;
  // Sources both enabled and active; the line lags immediate ones by one register stage, deferred ones by two.
  wire [5:0] a = status_o & irq_enable_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  chk_irq_off: assert property ((a == 0) [*2] |=> !irq_o)
    else $error("irq off");
  chk_irq_now: assert property (|(a & IMMEDIATE_MASK) |=> irq_o)
    else $error("irq now");
  chk_irq_thr: assert property (threshold_i && |(a & DEFERRED_MASK) |-> ##[1:2] irq_o)
    else $error("irq thr");
  chk_irq_hold: assert property (
    !irq_o && !threshold_i && !$past(threshold_i) && !(a & IMMEDIATE_MASK) |=> !irq_o)
    else $error("irq early");
  chk_flag_set: assert property (evt_i.port_change |=> status_o.port_change)
    else $error("flag");
  chk_roll_set: assert property (evt_i.rollover |=> status_o.rollover)
    else $error("roll");
  chk_fault_stop: assert property (
    evt_i.bus_fault |=> status_o.system_error && !run_stop_o) else $error("fault");
  chk_done_set: assert property (
    evt_i.ioc_retired || evt_i.short_packet |=> status_o.xfer_done) else $error("done");
endmodule : hcieg_gate_sva
bind hcieg_gate hcieg_gate_sva u_sva (.clk_i, .nrst_i, .evt_i, .threshold_i,
  .run_stop_o, .status_o, .irq_enable_o, .irq_o);

// file: bench/hcieg_host_model.sv
module hcieg_host_model (
  input logic clk_i,
  input logic ack_i,
  input hcieg_pkg::hcieg_src_t status_i,
  output hcieg_pkg::hcieg_src_t clr_o = '0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Polling software writes back every flag it saw, which acknowledges it.
  always @(posedge clk_i) clr_o <= #1 ack_i ? status_i : '0;
endmodule : hcieg_host_model

// file: bench/hcieg_gate_tb.sv
module hcieg_gate_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import hcieg_pkg::*;
  logic clk_i = 0, nrst_i = 0, threshold_i = 0, run_stop_set_i = 0, ack = 0;
  logic irq_o, run_stop_o;
  logic [31:0] rdata_o;
  hcieg_req_t req_i = '0;
  hcieg_evt_t evt_i = '0;
  hcieg_src_t status_clr_i, status_o, irq_enable_o;
  int errors = 0, checks = 0;
  // Enable, event, threshold, expected flags, expected line.
  logic [20:0] rows [10] = '{21'h1f81c1, 21'h1f8140, 21'h1f8211, 21'h1f8409, 21'h1f8885,
    21'h1f9083, 21'h1fa002, 21'h1fc021, 21'h0040a0, 21'h1d8408};
  always #20 clk_i = ~clk_i;
  hcieg_gate u_dut (.clk_i, .nrst_i, .req_i, .rdata_o, .evt_i, .status_clr_i, .threshold_i,
    .run_stop_set_i, .run_stop_o, .status_o, .irq_enable_o, .irq_o);
  hcieg_host_model u_host (.clk_i, .ack_i(ack), .status_i(status_o), .clr_o(status_clr_i));
  task automatic summarize;
    if (errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
    checks++;
    if (e !== s) $display("unexpected %s: expected %h seen %h", n, e, s);
    if (e !== s) errors++;
  endtask : cmp
  task automatic tick(int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  // Read data stands for one cycle only, so it is compared before the idle cycle.
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    req_i = '{w, !w, a, d};
    tick(1);
    req_i = '0;
    if (!w) cmp("rdata", d, rdata_o);
    tick(1);
  endtask : bus
  initial begin
    tick(16);
    nrst_i = 1;
    bus(0, IRQ_ENABLE_OFFSET, 0);
    foreach (rows[k]) begin
      bus(1, IRQ_ENABLE_OFFSET, rows[k][20:15]);
      cmp("enable", rows[k][20:15], irq_enable_o);
      evt_i = hcieg_evt_t'(rows[k][14:8]);
      tick(1);
      evt_i = '0;
      threshold_i = rows[k][7];
      tick(3);
      cmp("status", rows[k][6:1], status_o);
      cmp("irq", rows[k][0], irq_o);
      {ack, threshold_i} = 2'b10;
      tick(2);
      ack = 0;
      tick(3);
      cmp("acked", 0, {status_o, irq_o});
    end
    // Reserved bits are dropped on write and read back as zero.
    bus(1, IRQ_ENABLE_OFFSET, '1);
    bus(0, IRQ_ENABLE_OFFSET, 32'h3f);
    // A bus fault wins over a start request in the same cycle.
    run_stop_set_i = 1;
    tick(1);
    cmp("run", 1, run_stop_o);
    evt_i.bus_fault = 1;
    tick(1);
    cmp("run", 0, run_stop_o);
    // A reset after the fault clears every output, and a read follows one cycle after release.
    evt_i = '0;
    run_stop_set_i = 0;
    nrst_i = 0;
    tick(2);
    cmp("in reset", 0, {status_o, irq_enable_o, irq_o, run_stop_o});
    nrst_i = 1;
    tick(1);
    cmp("after reset", 0, {status_o, irq_enable_o, irq_o, run_stop_o});
    bus(0, IRQ_ENABLE_OFFSET, IRQ_ENABLE_RESET);
    summarize();
  end
endmodule : hcieg_gate_tb
